/* serial_port_defines.vh */
/*
 Constants of the FIFO serial port: register offsets, field positions,
 reset values, trigger levels and bit timing.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH

// Register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_BAUD 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_FIFO_CTRL 8'h0c
`define ADDR_FIFO_COUNT 8'h10
`define ADDR_TX_PORT 8'h14
`define ADDR_RX_PORT 8'h18

// Control register fields
`define CTRL_TE 0
`define CTRL_RE 1
`define CTRL_TIE 2
`define CTRL_RIE 3
`define CTRL_MODEM 4
`define CTRL_CHR 5
`define CTRL_PE 6
`define CTRL_ODD 7
`define CTRL_STOP 8
`define CTRL_PORT_LEVEL 9
`define CTRL_PORT_MD0 10
`define CTRL_PORT_MD1 11
`define CTRL_RESET 12'h000
`define BAUD_RESET 16'h0035

// Status register fields
`define ST_DR 0
`define ST_ER 1
`define ST_BRK 2
`define ST_RDF 3
`define ST_TX_FIFO_EMPTY_FLAG 4
`define ST_TRANSMIT_END_FLAG 5
`define ST_FER 6
`define ST_PER 7

// FIFO control fields
`define FC_TX_RST 4
`define FC_RX_RST 5
`define FC_RESET 6'h00

// FIFO sizing and trigger levels
`define FIFO_DEPTH 16
`define FIFO_FULL 5'd16
`define TX_TRIG0 5'd8
`define TX_TRIG1 5'd4
`define TX_TRIG2 5'd2
`define TX_TRIG3 5'd1
`define RX_TRIG0 5'd1
`define RX_TRIG1 5'd4
`define RX_TRIG2 5'd8
`define RX_TRIG3 5'd14

// Bit timing in base clock ticks
`define SAMPLE_PHASE 4'd7
`define LAST_PHASE 4'd15
`define DR_QUIET_TICKS 8'ha0

// Bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* byte_store.v */
/*
 Sixteen-word storage for one FIFO, read data registered.
 Assumes the caller presents the next read pointer on raddr each cycle.
*/
`timescale 1ns/1ps
`include "serial_port_defines.vh"

module byte_store #(
   parameter WIDTH = 8
) (
   // Clock
   input wire aclk,
   // Write side
   input wire we,
   input wire [3:0] waddr,
   input wire [WIDTH-1:0] wdata,
   // Read side
   input wire [3:0] raddr,
   output reg [WIDTH-1:0] rdata
);
   reg [WIDTH-1:0] mem [0:`FIFO_DEPTH-1];

   always @(posedge aclk) begin
      if (we)
         mem[waddr] <= wdata;
      // Bypass so a write into an empty FIFO is seen at once
      if (we && waddr == raddr)
         rdata <= wdata;
      else
         rdata <= mem[raddr];
   end
endmodule // byte_store

/* fifo_serial_port.v */
/*
 FIFO serial port: AXI4-Lite register slave, 16-entry transmit and
 receive FIFOs, 16x oversampling receiver, transmitter, modem handshake,
 four interrupt request lines and two DMA request lines.
 Assumes serial_in_pin and clear_to_send_in are asynchronous pins and
 dma_grant comes from logic on aclk.
*/
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "serial_port_defines.vh"

module fifo_serial_port (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write channels
   input wire [7:0] awaddr,
   input wire awvalid,
   output reg awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output reg wready,
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   // AXI4-Lite read channels
   input wire [7:0] araddr,
   input wire arvalid,
   output reg arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   // DMA marker for bus accesses
   input wire dma_grant,
   // Serial pins
   input wire serial_in_pin,
   output reg serial_out_pin,
   output reg serial_out_oe,
   input wire clear_to_send_in,
   output reg request_to_send_out,
   // Interrupt and DMA requests
   output reg tx_empty_irq,
   output reg rx_full_irq,
   output reg rx_error_irq,
   output reg break_irq,
   output reg tx_dma_req,
   output reg rx_dma_req
);
   localparam RX_IDLE = 4'b0001;
   localparam RX_START = 4'b0010;
   localparam RX_DATA = 4'b0100;
   localparam RX_STOP = 4'b1000;
   localparam TX_IDLE = 5'b00001;
   localparam TX_START = 5'b00010;
   localparam TX_DATA = 5'b00100;
   localparam TX_PAR = 5'b01000;
   localparam TX_STOP = 5'b10000;

   function [4:0] tx_trig_of;
      input [1:0] sel;
      case (sel)
         2'd0: tx_trig_of = `TX_TRIG0;
         2'd1: tx_trig_of = `TX_TRIG1;
         2'd2: tx_trig_of = `TX_TRIG2;
         default: tx_trig_of = `TX_TRIG3;
      endcase
   endfunction

   function [4:0] rx_trig_of;
      input [1:0] sel;
      case (sel)
         2'd0: rx_trig_of = `RX_TRIG0;
         2'd1: rx_trig_of = `RX_TRIG1;
         2'd2: rx_trig_of = `RX_TRIG2;
         default: rx_trig_of = `RX_TRIG3;
      endcase
   endfunction

   reg [11:0] serial_control_reg;
   reg [15:0] baud_div;
   reg [5:0] fifo_control_reg;
   reg data_ready_flag, receive_error_flag, break_flag;
   reg rx_fifo_full_flag, tx_fifo_empty_flag, transmit_end_flag;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [15:0] base_cnt;
   reg base_tick;
   reg rx_s1, rx_s2, rx_prev, cts_s1, cts_s2;
   reg [3:0] tx_wp, tx_rp, rx_wp, rx_rp;
   reg [4:0] tx_count, rx_count;
   wire [7:0] tx_rdata;
   wire [9:0] rx_rdata;
   reg [3:0] rx_state, rx_phase;
   reg [2:0] rx_bitn;
   reg [7:0] receive_shift_reg;
   reg rx_pbit, rx_in_par, break_line, rx_push, rx_err_evt;
   reg [9:0] rx_word;
   reg [7:0] quiet;
   reg [4:0] tx_state;
   reg [3:0] tx_phase;
   reg [2:0] tx_bitn;
   reg [7:0] tx_shift;
   reg tx_par, tx_line, tx_pop, stop_second, transmit_end_flag_evt;

   wire transmit_enable = serial_control_reg[`CTRL_TE];
   wire receive_enable = serial_control_reg[`CTRL_RE];
   wire tx_irq_enable = serial_control_reg[`CTRL_TIE];
   wire rx_irq_enable = serial_control_reg[`CTRL_RIE];
   wire modem_en = serial_control_reg[`CTRL_MODEM];
   wire char_length_bit = serial_control_reg[`CTRL_CHR];
   wire parity_enable_bit = serial_control_reg[`CTRL_PE];
   wire parity_odd = serial_control_reg[`CTRL_ODD];
   wire two_stop = serial_control_reg[`CTRL_STOP];
   wire port_out_level_bit = serial_control_reg[`CTRL_PORT_LEVEL];
   wire port_mode_bit0 = serial_control_reg[`CTRL_PORT_MD0];
   wire port_mode_bit1 = serial_control_reg[`CTRL_PORT_MD1];
   wire [4:0] tx_trig = tx_trig_of(fifo_control_reg[1:0]);
   wire [4:0] rx_trig = rx_trig_of(fifo_control_reg[3:2]);

   // Bus write commits once address and data are both held
   wire w_commit = !awready && !wready && !bvalid;
   reg wstrb_held;
   wire w_ok = w_commit && wstrb_held;
   wire st_wr = w_ok && aw_addr == `ADDR_STATUS;
   wire tx_push = w_ok && aw_addr == `ADDR_TX_PORT && tx_count != `FIFO_FULL;
   wire rd_take = arvalid && arready;
   wire rx_pop = rd_take && araddr == `ADDR_RX_PORT && rx_count != 5'd0;

   // Base clock at 16x bit rate from the baud divider
   always @(posedge aclk) begin
      if (!aresetn || base_cnt >= baud_div) begin
         base_cnt <= 16'h0000;
         base_tick <= aresetn;
      end else begin
         base_cnt <= base_cnt + 16'h0001;
         base_tick <= 1'b0;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
         rx_prev <= 1'b1;
         cts_s1 <= 1'b1;
         cts_s2 <= 1'b1;
      end else begin
         rx_s1 <= serial_in_pin;
         rx_s2 <= rx_s1;
         rx_prev <= rx_s2;
         cts_s1 <= clear_to_send_in;
         cts_s2 <= cts_s1;
      end
   end

   // FIFO pointers and counts
   always @(posedge aclk) begin
      if (!aresetn || fifo_control_reg[`FC_TX_RST]) begin
         tx_wp <= 4'h0;
         tx_rp <= 4'h0;
         tx_count <= 5'd0;
      end else begin
         if (tx_push)
            tx_wp <= tx_wp + 4'h1;
         if (tx_pop)
            tx_rp <= tx_rp + 4'h1;
         tx_count <= tx_count + {4'h0, tx_push} - {4'h0, tx_pop};
      end
   end

   always @(posedge aclk) begin
      if (!aresetn || fifo_control_reg[`FC_RX_RST]) begin
         rx_wp <= 4'h0;
         rx_rp <= 4'h0;
         rx_count <= 5'd0;
      end else begin
         if (rx_push)
            rx_wp <= rx_wp + 4'h1;
         if (rx_pop)
            rx_rp <= rx_rp + 4'h1;
         rx_count <= rx_count + {4'h0, rx_push} - {4'h0, rx_pop};
      end
   end

   byte_store #(.WIDTH(8)) tx_store (
      .aclk(aclk),
      .we(tx_push),
      .waddr(tx_wp),
      .wdata(w_data[7:0]),
      .raddr(tx_rp + {3'h0, tx_pop}),
      .rdata(tx_rdata)
   );

   byte_store #(.WIDTH(10)) rx_store (
      .aclk(aclk),
      .we(rx_push),
      .waddr(rx_wp),
      .wdata(rx_word),
      .raddr(rx_rp + {3'h0, rx_pop}),
      .rdata(rx_rdata)
   );

   // Receiver
   wire rx_last = rx_bitn == (char_length_bit ? 3'd6 : 3'd7);
   wire [7:0] rx_data = char_length_bit ? {1'b0, receive_shift_reg[7:1]} : receive_shift_reg;
   wire rx_fer = !rx_s2;
   wire rx_per = parity_enable_bit && (^rx_data ^ rx_pbit ^ parity_odd);
   wire rx_is_brk = rx_fer && rx_data == 8'h00;

   always @(posedge aclk) begin
      rx_push <= 1'b0;
      rx_err_evt <= 1'b0;
      if (!aresetn || !receive_enable) begin
         rx_state <= RX_IDLE;
         rx_phase <= 4'h0;
         rx_bitn <= 3'd0;
         receive_shift_reg <= 8'h00;
         rx_pbit <= 1'b0;
         rx_in_par <= 1'b0;
         break_line <= 1'b0;
         rx_word <= 10'h000;
      end else begin
         if (rx_s2)
            break_line <= 1'b0;
         if (rx_state == RX_IDLE) begin
            if (rx_prev && !rx_s2) begin
               rx_state <= RX_START;
               rx_phase <= 4'h0;
            end
         end else if (base_tick) begin
            rx_phase <= rx_phase + 4'h1;
            if (rx_phase == `SAMPLE_PHASE) begin
               case (rx_state)
                  RX_START: begin
                     rx_state <= rx_s2 ? RX_IDLE : RX_DATA;
                     rx_bitn <= 3'd0;
                     rx_in_par <= 1'b0;
                  end
                  RX_DATA: begin
                     if (rx_in_par) begin
                        rx_pbit <= rx_s2;
                        rx_state <= RX_STOP;
                     end else begin
                        receive_shift_reg <= {rx_s2, receive_shift_reg[7:1]};
                        rx_bitn <= rx_bitn + 3'd1;
                        if (rx_last) begin
                           rx_in_par <= parity_enable_bit;
                           if (!parity_enable_bit)
                              rx_state <= RX_STOP;
                        end
                     end
                  end
                  RX_STOP: begin
                     // Second stop bit is not examined; idle waits for next fall
                     rx_state <= RX_IDLE;
                     rx_word <= {rx_per, rx_fer, rx_data};
                     rx_push <= (!rx_fer || rx_is_brk) && rx_count != `FIFO_FULL && !break_flag;
                     rx_err_evt <= rx_fer || rx_per;
                     if (rx_is_brk)
                        break_line <= 1'b1;
                  end
                  default: rx_state <= RX_IDLE;
               endcase
            end
         end
      end
   end

   // Quiet line with data below trigger marks data ready
   always @(posedge aclk) begin
      if (!aresetn || rx_state != RX_IDLE)
         quiet <= 8'h00;
      else if (base_tick && quiet != `DR_QUIET_TICKS)
         quiet <= quiet + 8'h01;
   end
   wire dr_evt = base_tick && quiet == `DR_QUIET_TICKS - 8'h01 && rx_count != 5'd0 && rx_count < rx_trig;

   // Transmitter
   wire tx_go = tx_count != 5'd0 && !(modem_en && cts_s2);
   wire [7:0] tx_load = char_length_bit ? {1'b0, tx_rdata[6:0]} : tx_rdata;

   always @(posedge aclk) begin
      tx_pop <= 1'b0;
      transmit_end_flag_evt <= 1'b0;
      if (!aresetn || !transmit_enable) begin
         tx_state <= TX_IDLE;
         tx_phase <= 4'h0;
         tx_bitn <= 3'd0;
         tx_shift <= 8'h00;
         tx_par <= 1'b0;
         tx_line <= 1'b1;
         stop_second <= 1'b0;
      end else if (tx_state == TX_IDLE || (tx_state == TX_STOP && base_tick && tx_phase == `LAST_PHASE &&
                   !(two_stop && !stop_second))) begin
         if (tx_go) begin
            tx_pop <= 1'b1;
            tx_shift <= tx_load;
            tx_par <= ^tx_load ^ parity_odd;
            tx_state <= TX_START;
            tx_line <= 1'b0;
         end else begin
            tx_state <= TX_IDLE;
            tx_line <= 1'b1;
         end
         tx_phase <= 4'h0;
      end else if (base_tick) begin
         tx_phase <= tx_phase + 4'h1;
         if (tx_phase == `LAST_PHASE) begin
            case (tx_state)
               TX_START: begin
                  tx_state <= TX_DATA;
                  tx_bitn <= 3'd0;
                  tx_line <= tx_shift[0];
               end
               TX_DATA: begin
                  if (tx_bitn == (char_length_bit ? 3'd6 : 3'd7)) begin
                     tx_state <= parity_enable_bit ? TX_PAR : TX_STOP;
                     tx_line <= parity_enable_bit ? tx_par : 1'b1;
                     stop_second <= 1'b0;
                     transmit_end_flag_evt <= !parity_enable_bit && tx_count == 5'd0;
                  end else begin
                     tx_shift <= {1'b0, tx_shift[7:1]};
                     tx_line <= tx_shift[1];
                     tx_bitn <= tx_bitn + 3'd1;
                  end
               end
               TX_PAR: begin
                  tx_state <= TX_STOP;
                  tx_line <= 1'b1;
                  stop_second <= 1'b0;
                  transmit_end_flag_evt <= tx_count == 5'd0;
               end
               TX_STOP: stop_second <= 1'b1;
               default: tx_state <= TX_IDLE;
            endcase
         end
      end
   end

   // Status flags: hardware set wins over a clear
   wire tx_fifo_empty_flag_clr = (st_wr && !w_data[`ST_TX_FIFO_EMPTY_FLAG]) || (tx_push && dma_grant);
   wire rdf_clr = (st_wr && !w_data[`ST_RDF]) || (rx_pop && dma_grant);
   always @(posedge aclk) begin
      if (!aresetn) begin
         data_ready_flag <= 1'b0;
         receive_error_flag <= 1'b0;
         break_flag <= 1'b0;
         rx_fifo_full_flag <= 1'b0;
         tx_fifo_empty_flag <= 1'b1;
         transmit_end_flag <= 1'b1;
      end else begin
         data_ready_flag <= dr_evt || (data_ready_flag && !(st_wr && !w_data[`ST_DR]));
         receive_error_flag <= rx_err_evt || (receive_error_flag && !(st_wr && !w_data[`ST_ER]));
         break_flag <= (break_line && !rx_s2) || (break_flag && !(st_wr && !w_data[`ST_BRK]));
         rx_fifo_full_flag <= rx_count >= rx_trig || (rx_fifo_full_flag && !rdf_clr);
         tx_fifo_empty_flag <= tx_count < tx_trig || (tx_fifo_empty_flag_clr && tx_count <= tx_trig) ||
                               (tx_fifo_empty_flag && !tx_fifo_empty_flag_clr);
         transmit_end_flag <= transmit_end_flag_evt || (transmit_end_flag && !(st_wr && !w_data[`ST_TRANSMIT_END_FLAG]));
      end
   end

   // Request lines, pins and handshake
   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_empty_irq <= 1'b0;
         rx_full_irq <= 1'b0;
         rx_error_irq <= 1'b0;
         break_irq <= 1'b0;
         tx_dma_req <= 1'b0;
         rx_dma_req <= 1'b0;
         request_to_send_out <= 1'b0;
         serial_out_pin <= 1'b1;
         serial_out_oe <= 1'b0;
      end else begin
         tx_empty_irq <= tx_irq_enable && tx_fifo_empty_flag;
         rx_full_irq <= rx_irq_enable && (rx_fifo_full_flag || data_ready_flag);
         rx_error_irq <= rx_irq_enable && receive_error_flag;
         break_irq <= rx_irq_enable && break_flag;
         tx_dma_req <= tx_irq_enable && tx_fifo_empty_flag;
         rx_dma_req <= rx_irq_enable && rx_fifo_full_flag;
         request_to_send_out <= modem_en && rx_count == `FIFO_FULL;
         serial_out_pin <= transmit_enable ? tx_line : port_out_level_bit;
         serial_out_oe <= transmit_enable || (port_mode_bit1 && !port_mode_bit0);
      end
   end

   // Highest pending enabled source: 4 error, 3 receive, 2 break, 1 transmit
   wire [2:0] irq_prio = rx_error_irq ? 3'd4 : rx_full_irq ? 3'd3 : break_irq ? 3'd2 :
                         tx_empty_irq ? 3'd1 : 3'd0;

   // AXI4-Lite write path
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         wstrb_held <= 1'b0;
         serial_control_reg <= `CTRL_RESET;
         baud_div <= `BAUD_RESET;
         fifo_control_reg <= `FC_RESET;
      end else begin
         if (awvalid && awready) begin
            aw_addr <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_data <= wdata;
            wstrb_held <= wstrb[0];
            wready <= 1'b0;
         end
         if (bvalid && bready)
            bvalid <= 1'b0;
         if (w_commit) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b1;
            bresp <= `RESP_OKAY;
            case (aw_addr)
               `ADDR_CTRL: if (wstrb_held) serial_control_reg <= w_data[11:0];
               `ADDR_BAUD: if (wstrb_held) baud_div <= w_data[15:0];
               `ADDR_FIFO_CTRL: if (wstrb_held) fifo_control_reg <= w_data[5:0];
               `ADDR_STATUS, `ADDR_TX_PORT: bresp <= `RESP_OKAY;
               default: bresp <= `RESP_SLVERR;
            endcase
         end
      end
   end

   // AXI4-Lite read path
   always @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `RESP_OKAY;
      end else if (rd_take) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= `RESP_OKAY;
         case (araddr)
            `ADDR_CTRL: rdata <= {20'h00000, serial_control_reg};
            `ADDR_BAUD: rdata <= {16'h0000, baud_div};
            `ADDR_STATUS: rdata <= {21'h000000, irq_prio,
                                    rx_count != 5'd0 && rx_rdata[9], rx_count != 5'd0 && rx_rdata[8],
                                    transmit_end_flag, tx_fifo_empty_flag, rx_fifo_full_flag,
                                    break_flag, receive_error_flag, data_ready_flag};
            `ADDR_FIFO_CTRL: rdata <= {26'h0000000, fifo_control_reg};
            `ADDR_FIFO_COUNT: rdata <= {16'h0000, 3'h0, tx_count, 3'h0, rx_count};
            `ADDR_RX_PORT: rdata <= {24'h000000, rx_count != 5'd0 ? rx_rdata[7:0] : 8'h00};
            `ADDR_TX_PORT: rdata <= 32'h00000000;
            default: begin
               rdata <= 32'h00000000;
               rresp <= `RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end
endmodule // fifo_serial_port

/* fifo_uart_rx_flow_irq_props.sv */
/* Checker on the serial port top: bus answers, start bit, request lines.
 Assumes it is bound onto every fifo_serial_port. */
`timescale 1ns/1ps
module port_checker (
   // Clock and reset
   input wire aclk, aresetn,
   // Bus handshakes
   input wire awvalid, awready, wvalid, wready, bvalid, bready,
   input wire arvalid, arready, rvalid, rready,
   input wire [1:0] rresp,
   input wire [31:0] rdata,
   // Serial line and requests
   input wire serial_out_pin, serial_out_oe,
   input wire tx_empty_irq, rx_full_irq, tx_dma_req, rx_dma_req
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_write_answer: assert property (awvalid && awready && wvalid && wready |=> !awready ##1 bvalid)
      else $error("write answer late");
   chk_write_release: assert property (bvalid && bready |=> !bvalid && awready)
      else $error("write answer not released");
   chk_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read answer late");
   chk_read_release: assert property (rvalid && rready |=> !rvalid && arready)
      else $error("read answer not released");
   chk_error_zero: assert property (rvalid && rresp == 2'b10 |-> rdata == 32'h0)
      else $error("refused read carries data");
   chk_tx_dma: assert property (tx_dma_req == tx_empty_irq)
      else $error("transmit request lines differ");
   chk_rx_dma: assert property (rx_dma_req |-> rx_full_irq)
      else $error("receive transfer request without interrupt");
   chk_start_bit: assert property ($fell(serial_out_pin) && serial_out_oe |=> !serial_out_pin [*8])
      else $error("start bit too short");
endmodule // port_checker
bind fifo_serial_port port_checker i_chk (.*);

/* serial_peer.sv */
/* Remote serial peer: sends frames to the port and decodes its output.
 Assumes one bit lasts BIT clocks of aclk. */
`timescale 1ns/1ps
module serial_peer #(parameter int BIT = 16) (
   // Clock
   input wire aclk,
   // Serial lines
   input wire line_from_port,
   output logic line_to_port
);
   logic [7:0] got = 8'h00;
   int n_got = 0;
   initial line_to_port = 1'b1;
   // Start low, data LSB first, chosen stop level, then mark
   task automatic send(input logic [7:0] v, input logic stop);
      begin
         line_to_port <= 1'b0;
         repeat (BIT) @(posedge aclk);
         for (int i = 0; i < 8; i++) begin
            line_to_port <= v[i];
            repeat (BIT) @(posedge aclk);
         end
         line_to_port <= stop;
         repeat (BIT) @(posedge aclk);
         line_to_port <= 1'b1;
         repeat (2 * BIT) @(posedge aclk);
      end
   endtask
   // Samples mid-bit after each falling start edge
   always begin
      @(negedge line_from_port);
      repeat (BIT / 2) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge aclk);
         got[i] = line_from_port;
      end
      repeat (BIT) @(posedge aclk);
      n_got++;
   end
endmodule // serial_peer

/* fifo_uart_rx_flow_irq_bench.sv */
/* Bench of the FIFO serial port: bus tasks, serial peer, scenarios.
 Assumes a baud divisor of 0, so one bit is 16 clocks. */
`timescale 1ns/1ps
module fifo_uart_rx_flow_irq_bench;
   logic aclk = 1'b0, aresetn = 1'b0, dma_grant = 1'b0, clear_to_send_in = 1'b0, serial_in_pin;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, d;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] r;
   wire awready, wready, bvalid, arready, rvalid, serial_out_pin, serial_out_oe, request_to_send_out;
   wire tx_empty_irq, rx_full_irq, rx_error_irq, break_irq, tx_dma_req, rx_dma_req;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int checks = 0, n_mismatch = 0;
   fifo_serial_port i_dut (.*);
   // Released transmit line idles high on its pull-up
   serial_peer i_peer (.aclk(aclk), .line_from_port(serial_out_oe ? serial_out_pin : 1'b1),
                       .line_to_port(serial_in_pin));
   initial forever #5 aclk = ~aclk;
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      begin
         awaddr <= a;
         wdata <= v;
         {awvalid, wvalid, bready} <= 3'b111;
         do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
         end while (!bvalid);
         bready <= 1'b0;
         @(posedge aclk);
      end
   endtask
   task automatic axr(input logic [7:0] a);
      begin
         araddr <= a;
         {arvalid, rready} <= 2'b11;
         do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
         end while (!rvalid);
         d = rdata;
         r = rresp;
         rready <= 1'b0;
         @(posedge aclk);
      end
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      begin
         checks++;
         if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, g, e);
         end
      end
   endtask
   task automatic wait_peer(input int n);
      for (int i = 0; i < 3000 && i_peer.n_got < n; i++) @(posedge aclk);
   endtask
   task automatic tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", checks, n_mismatch);
         if (n_mismatch == 0 && checks > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   initial begin
      repeat (30000) @(posedge aclk);
      n_mismatch++;
      tally_and_finish;
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axw(8'h04, 32'h0);
      axr(8'h08);
      chk(d & 32'hff, 32'h30);
      axr(8'h1c);
      chk(32'(r), 32'h2);
      $display("registers done");
      axw(8'h00, 32'h0f);
      repeat (2) @(posedge aclk);
      chk(32'(tx_empty_irq), 32'h1);
      chk(32'(tx_dma_req), 32'h1);
      axw(8'h08, 32'hdf);
      axr(8'h08);
      chk(32'(d[5]), 32'h0);
      axw(8'h14, 32'ha5);
      wait_peer(1);
      chk(32'(i_peer.got), 32'ha5);
      axr(8'h08);
      chk(32'(d[5]), 32'h1);
      $display("transmit done");
      i_peer.send(8'h3c, 1'b1);
      axr(8'h10);
      chk(d, 32'h1);
      chk(32'(rx_full_irq), 32'h1);
      chk(32'(rx_dma_req), 32'h1);
      axr(8'h18);
      chk(d, 32'h3c);
      i_peer.send(8'h55, 1'b0);
      axr(8'h10);
      chk(d, 32'h0);
      axr(8'h08);
      chk(32'(d[1]), 32'h1);
      chk(32'(rx_error_irq), 32'h1);
      i_peer.send(8'h11, 1'b1);
      axr(8'h18);
      chk(d, 32'h11);
      i_peer.send(8'h00, 1'b0);
      axr(8'h08);
      chk(d & 32'h44, 32'h44);
      chk(32'(break_irq), 32'h1);
      axw(8'h08, 32'hfb);
      axr(8'h18);
      chk(d, 32'h0);
      $display("receive done");
      axw(8'h00, 32'h1f);
      repeat (2) @(posedge aclk);
      chk(32'(request_to_send_out), 32'h0);
      for (int i = 1; i < 17; i++) i_peer.send(8'(i), 1'b1);
      chk(32'(request_to_send_out), 32'h1);
      i_peer.send(8'hee, 1'b1);
      axr(8'h10);
      chk(d, 32'h10);
      axr(8'h18);
      chk(d, 32'h1);
      clear_to_send_in <= 1'b1;
      repeat (4) @(posedge aclk);
      axw(8'h14, 32'h5a);
      repeat (300) @(posedge aclk);
      chk(32'(i_peer.n_got), 32'h1);
      axr(8'h10);
      chk(d, 32'h10f);
      chk(32'(request_to_send_out), 32'h0);
      clear_to_send_in <= 1'b0;
      wait_peer(2);
      chk(32'(i_peer.got), 32'h5a);
      repeat (16) @(posedge aclk);
      axw(8'h00, 32'h81e);
      chk(32'({serial_out_oe, serial_out_pin}), 32'h2);
      $display("flow control done");
      tally_and_finish;
   end
endmodule // fifo_uart_rx_flow_irq_bench
